/* File: hdl/ecps_pkg.sv */
// Constants and types for the soft pin and speed check control block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package ecps_pkg;

  // ---------------------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------------------
  typedef logic [7:0] ecps_addr_t;
  typedef logic [31:0] ecps_data_t;

  localparam ecps_addr_t ECPS_OFF_EXT_CTRL = 8'h18;
  localparam ecps_addr_t ECPS_OFF_IRQ_STATUS = 8'h40;
  localparam ecps_addr_t ECPS_OFF_IRQ_MASK = 8'h44;
  localparam ecps_addr_t ECPS_OFF_SPEED_RESULT = 8'h48;

  // ---------------------------------------------------------------------------
  // Field layout of the extended control register
  // ---------------------------------------------------------------------------
  localparam int unsigned ECPS_NUM_PINS = 2;
  localparam int unsigned ECPS_IRQ_EN_LSB = 2;
  localparam int unsigned ECPS_VALUE_LSB = 6;
  localparam int unsigned ECPS_DIR_LSB = 10;
  localparam int unsigned ECPS_TRIG_BIT = 12;

  // ---------------------------------------------------------------------------
  // Interrupt status layout and speed result width
  // ---------------------------------------------------------------------------
  localparam int unsigned ECPS_EVT_W = 3;
  localparam int unsigned ECPS_EVT_GPI_LSB = 0;
  localparam int unsigned ECPS_EVT_SPEED = 2;
  localparam int unsigned ECPS_RESULT_W = 2;

  typedef logic [ECPS_NUM_PINS-1:0] ecps_pins_t;
  typedef logic [ECPS_EVT_W-1:0] ecps_evt_t;
  typedef logic [ECPS_RESULT_W-1:0] ecps_result_t;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam ecps_pins_t ECPS_RST_DIR = 2'h0;
  localparam ecps_pins_t ECPS_RST_VALUE = 2'h0;
  localparam ecps_pins_t ECPS_RST_IRQ_EN = 2'h0;
  localparam ecps_evt_t ECPS_RST_EVT = 3'h0;
  localparam ecps_result_t ECPS_RST_RESULT = 2'h0;
  localparam ecps_data_t ECPS_RST_RDATA = 32'h0000_0000;

  typedef enum logic [1:0] {
    ECPS_SPD_IDLE,
    ECPS_SPD_REQ,
    ECPS_SPD_BUSY
  } ecps_spd_state_e;

endpackage

/* File: hdl/ecps_irq_if.sv */
// Interrupt status and mask signals between the core and the interrupt unit
`timescale 1ns/1ps
`default_nettype none
interface ecps_irq_if;
  import ecps_pkg::*;
  ecps_evt_t evt;
  logic status_rd;
  logic mask_wr;
  ecps_evt_t mask_wdata;
  ecps_evt_t status;
  ecps_evt_t mask;
  logic irq;

  modport core (
    output evt, status_rd, mask_wr, mask_wdata,
    input status, mask, irq
  );
  modport unit (
    input evt, status_rd, mask_wr, mask_wdata,
    output status, mask, irq
  );
endinterface
`default_nettype wire

/* File: hdl/ecps_pin_sync.sv */
// Two-stage pin synchroniser with a rising transition detector
`timescale 1ns/1ps
`default_nettype none
module ecps_pin_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Pin side
  input wire logic i_pin,
  // Sampled level and edge
  output logic o_level,
  output logic o_rise
);
  import ecps_pkg::*;

  logic meta_ff;
  logic level_ff;
  logic prev_ff;

  // Only the second stage reads the first; metastability stays contained
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_ff <= 1'b0;
      level_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= i_pin;
      level_ff <= meta_ff;
      prev_ff <= level_ff;
    end
  end

  assign o_level = level_ff;
  assign o_rise = level_ff & ~prev_ff;
endmodule
`default_nettype wire

/* File: hdl/ecps_irq.sv */
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
module ecps_irq (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Core side
  ecps_irq_if.unit bus
);
  import ecps_pkg::*;

  ecps_evt_t status_ff;
  ecps_evt_t mask_ff;
  logic irq_ff;
  ecps_evt_t nxt_status;

  // An event in the clearing read's cycle survives the clear
  always_comb begin
    nxt_status = status_ff;
    if (bus.status_rd) begin
      nxt_status = ECPS_RST_EVT;
    end
    nxt_status = nxt_status | bus.evt;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      status_ff <= ECPS_RST_EVT;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      mask_ff <= ECPS_RST_EVT;
    end else if (bus.mask_wr) begin
      mask_ff <= bus.mask_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & (bus.mask_wr ? bus.mask_wdata : mask_ff));
    end
  end

  assign bus.status = status_ff;
  assign bus.mask = mask_ff;
  assign bus.irq = irq_ff;

  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
    bus.irq == |(status_ff & mask_ff))
    else $error("interrupt output does not match masked status");

  a_event_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (bus.evt != ECPS_RST_EVT) |=> ((status_ff & $past(bus.evt)) ==
      $past(bus.evt)))
    else $error("event lost from status");
endmodule
`default_nettype wire

/* File: hdl/ecps_top.sv */
// Extended control: two soft pins, interrupt detection and speed check
`timescale 1ns/1ps
`default_nettype none
module ecps_top (
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_por_resetn,
  // Register port
  input wire ecps_pkg::ecps_addr_t i_addr,
  input wire ecps_pkg::ecps_data_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output ecps_pkg::ecps_data_t o_rdata,
  // Power-on configuration from nonvolatile memory
  input wire logic i_nvm_load,
  input wire ecps_pkg::ecps_pins_t i_nvm_dir,
  input wire ecps_pkg::ecps_pins_t i_nvm_value,
  // Soft pins
  input wire ecps_pkg::ecps_pins_t i_soft_pin_in,
  output ecps_pkg::ecps_pins_t o_soft_pin_out,
  output ecps_pkg::ecps_pins_t o_soft_pin_oe,
  // Speed detection engine
  output logic o_speed_detect_start,
  input wire logic i_speed_detect_ack,
  input wire logic i_speed_detect_done,
  input wire ecps_pkg::ecps_result_t i_speed_detect_result,
  // Interrupt
  output logic o_irq
);
  import ecps_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  function automatic logic addr_is(input ecps_addr_t a, input ecps_addr_t off);
    addr_is = (a == off);
  endfunction

  logic rst_n;
  logic wr_ext;
  logic rd_ext;
  logic wr_mask;
  logic rd_status;
  logic rd_mask;
  logic rd_result;

  // Software or system reset, or power-on, clears ordinary control state
  assign rst_n = i_resetn & i_por_resetn;
  assign wr_ext = i_wr & addr_is(i_addr, ECPS_OFF_EXT_CTRL);
  assign rd_ext = i_rd & addr_is(i_addr, ECPS_OFF_EXT_CTRL);
  assign wr_mask = i_wr & addr_is(i_addr, ECPS_OFF_IRQ_MASK);
  assign rd_status = i_rd & addr_is(i_addr, ECPS_OFF_IRQ_STATUS);
  assign rd_mask = i_rd & addr_is(i_addr, ECPS_OFF_IRQ_MASK);
  assign rd_result = i_rd & addr_is(i_addr, ECPS_OFF_SPEED_RESULT);

  // ---------------------------------------------------------------------------
  // Pin control fields
  // ---------------------------------------------------------------------------
  ecps_pins_t dir_ff;
  ecps_pins_t value_ff;
  ecps_pins_t irq_en_ff;
  ecps_pins_t wr_dir;
  ecps_pins_t wr_value;
  ecps_pins_t wr_irq_en;

  // Reserved bits 1:0, 5:4 and 9:8 are never stored, so stray ones are inert
  assign wr_dir = i_wdata[ECPS_DIR_LSB +: ECPS_NUM_PINS];
  assign wr_value = i_wdata[ECPS_VALUE_LSB +: ECPS_NUM_PINS];
  assign wr_irq_en = i_wdata[ECPS_IRQ_EN_LSB +: ECPS_NUM_PINS];

  // Direction sees only power-on, the configuration load and writes
  always_ff @(posedge i_clk) begin
    if (!i_por_resetn) begin
      dir_ff <= ECPS_RST_DIR;
    end else if (wr_ext) begin
      dir_ff <= wr_dir;
    end else if (i_nvm_load) begin
      dir_ff <= i_nvm_dir;
    end
  end

  // Output value is kept across soft reset too so a driven pin does not glitch
  always_ff @(posedge i_clk) begin
    if (!i_por_resetn) begin
      value_ff <= ECPS_RST_VALUE;
    end else if (wr_ext) begin
      value_ff <= wr_value;
    end else if (i_nvm_load) begin
      value_ff <= i_nvm_value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      irq_en_ff <= ECPS_RST_IRQ_EN;
    end else if (wr_ext) begin
      irq_en_ff <= wr_irq_en;
    end
  end

  assign o_soft_pin_out = value_ff;
  assign o_soft_pin_oe = dir_ff;

  // ---------------------------------------------------------------------------
  // Pin sampling and interrupt detection
  // ---------------------------------------------------------------------------
  ecps_pins_t pin_level;
  ecps_pins_t pin_rise;
  ecps_pins_t gpi_evt;

  for (genvar p = 0; p < ECPS_NUM_PINS; p++) begin : g_pin
    ecps_pin_sync u_sync (
      .i_clk(i_clk),
      .i_resetn(rst_n),
      .i_pin(i_soft_pin_in[p]),
      .o_level(pin_level[p]),
      .o_rise(pin_rise[p])
    );
    // A driven pin never reports; its own output would echo back
    assign gpi_evt[p] = pin_rise[p] & irq_en_ff[p] & ~dir_ff[p];
  end

  // ---------------------------------------------------------------------------
  // Speed detection request
  // ---------------------------------------------------------------------------
  ecps_spd_state_e state_ff;
  ecps_spd_state_e nxt_state;
  logic start_ff;
  ecps_result_t result_ff;
  logic spd_evt;

  // A trigger while a check is under way is dropped, not queued
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ECPS_SPD_IDLE: begin
        if (wr_ext && i_wdata[ECPS_TRIG_BIT]) begin
          nxt_state = ECPS_SPD_REQ;
        end
      end
      ECPS_SPD_REQ: begin
        if (i_speed_detect_ack) begin
          nxt_state = ECPS_SPD_BUSY;
        end
      end
      ECPS_SPD_BUSY: begin
        if (i_speed_detect_done) begin
          nxt_state = ECPS_SPD_IDLE;
        end
      end
      default: begin
        nxt_state = ECPS_SPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      state_ff <= ECPS_SPD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= (nxt_state == ECPS_SPD_REQ);
    end
  end

  assign spd_evt = (state_ff == ECPS_SPD_BUSY) & i_speed_detect_done;

  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      result_ff <= ECPS_RST_RESULT;
    end else if (spd_evt) begin
      result_ff <= i_speed_detect_result;
    end
  end

  assign o_speed_detect_start = start_ff;

  // ---------------------------------------------------------------------------
  // Interrupt unit
  // ---------------------------------------------------------------------------
  ecps_irq_if u_irq_if ();

  assign u_irq_if.evt = {spd_evt, gpi_evt};
  assign u_irq_if.status_rd = rd_status;
  assign u_irq_if.mask_wr = wr_mask;
  assign u_irq_if.mask_wdata = i_wdata[ECPS_EVT_W-1:0];

  ecps_irq u_irq (
    .i_clk(i_clk),
    .i_resetn(rst_n),
    .bus(u_irq_if.unit)
  );

  assign o_irq = u_irq_if.irq;

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  ecps_data_t ext_view;
  ecps_data_t nxt_rdata;
  ecps_data_t rdata_ff;
  ecps_pins_t value_view;

  // Inputs read the sampled pin, outputs read back the driven value
  assign value_view = (dir_ff & value_ff) | (~dir_ff & pin_level);

  always_comb begin
    ext_view = ECPS_RST_RDATA;
    ext_view[ECPS_IRQ_EN_LSB +: ECPS_NUM_PINS] = irq_en_ff;
    ext_view[ECPS_VALUE_LSB +: ECPS_NUM_PINS] = value_view;
    ext_view[ECPS_DIR_LSB +: ECPS_NUM_PINS] = dir_ff;
    ext_view[ECPS_TRIG_BIT] = (state_ff == ECPS_SPD_REQ);
  end

  always_comb begin
    nxt_rdata = ECPS_RST_RDATA;
    if (rd_ext) begin
      nxt_rdata = ext_view;
    end else if (rd_status) begin
      nxt_rdata[ECPS_EVT_W-1:0] = u_irq_if.status;
    end else if (rd_mask) begin
      nxt_rdata[ECPS_EVT_W-1:0] = u_irq_if.mask;
    end else if (rd_result) begin
      nxt_rdata[ECPS_RESULT_W-1:0] = result_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      rdata_ff <= ECPS_RST_RDATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_trig_write;
    wr_ext && i_wdata[ECPS_TRIG_BIT] && state_ff == ECPS_SPD_IDLE;
  endsequence

  sequence s_accepted;
    o_speed_detect_start && i_speed_detect_ack;
  endsequence

  sequence s_busy_no_done;
    state_ff == ECPS_SPD_BUSY && !i_speed_detect_done;
  endsequence

  a_dir_only_write: assert property (@(posedge i_clk)
    disable iff (!i_por_resetn)
    (!wr_ext && !i_nvm_load) |=> $stable(o_soft_pin_oe))
    else $error("pin direction changed without write or load");

  a_dir_a_write: assert property (@(posedge i_clk)
    disable iff (!i_por_resetn)
    wr_ext |=> o_soft_pin_oe[0] == $past(i_wdata[ECPS_DIR_LSB]))
    else $error("pin a direction not taken from write");

  a_dir_b_write: assert property (@(posedge i_clk)
    disable iff (!i_por_resetn)
    wr_ext |=> o_soft_pin_oe[1] == $past(i_wdata[ECPS_DIR_LSB+1]))
    else $error("pin b direction not taken from write");

  a_nvm_load: assert property (@(posedge i_clk)
    disable iff (!i_por_resetn)
    (i_nvm_load && !wr_ext) |=> o_soft_pin_oe == $past(i_nvm_dir) &&
      o_soft_pin_out == $past(i_nvm_value))
    else $error("configuration load not applied to pins");

  a_value_a_drive: assert property (@(posedge i_clk)
    disable iff (!i_por_resetn)
    wr_ext |=> o_soft_pin_out[0] == $past(i_wdata[ECPS_VALUE_LSB]))
    else $error("pin a drive value not taken from write");

  a_read_pin_b: assert property (@(posedge i_clk) disable iff (!rst_n)
    (rd_ext && !dir_ff[1]) |=>
      o_rdata[ECPS_VALUE_LSB+1] == $past(pin_level[1]))
    else $error("pin b input level not returned on read");

  a_trig_start: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_trig_write |=> o_speed_detect_start)
    else $error("speed check not started by trigger write");

  a_trig_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_accepted |=> !o_speed_detect_start &&
      !ext_view[ECPS_TRIG_BIT] ##1 !o_speed_detect_start)
    else $error("trigger did not clear after acceptance");

  a_gpi_rise_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pin_rise[0] && irq_en_ff[0] && !dir_ff[0]) |=>
      u_irq_if.status[ECPS_EVT_GPI_LSB])
    else $error("pin a rising edge did not set interrupt cause");

  a_gpi_gate_b: assert property (@(posedge i_clk) disable iff (!rst_n)
    ((dir_ff[1] || !irq_en_ff[1]) && !rd_status) |=>
      $stable(u_irq_if.status[ECPS_EVT_GPI_LSB+1]))
    else $error("pin b cause raised while not an enabled input");

  a_gpi_gate_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    ((dir_ff[0] || !irq_en_ff[0]) && !rd_status) |=>
      $stable(u_irq_if.status[ECPS_EVT_GPI_LSB]))
    else $error("pin a cause raised while not an enabled input");

  a_gpi_rise_b: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pin_rise[1] && irq_en_ff[1] && !dir_ff[1]) |=>
      u_irq_if.status[ECPS_EVT_GPI_LSB+1])
    else $error("pin b rising edge did not set interrupt cause");

  a_value_b_drive: assert property (@(posedge i_clk)
    disable iff (!i_por_resetn)
    wr_ext |=> o_soft_pin_out[1] == $past(i_wdata[ECPS_VALUE_LSB+1]))
    else $error("pin b drive value not taken from write");

  a_read_pin_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (rd_ext && !dir_ff[0]) |=>
      o_rdata[ECPS_VALUE_LSB] == $past(pin_level[0]))
    else $error("pin a input level not returned on read");

  a_read_drive_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (rd_ext && dir_ff[0]) |=>
      o_rdata[ECPS_VALUE_LSB] == $past(value_ff[0]))
    else $error("pin a driven value not returned on read");

  a_trig_busy_drop: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_busy_no_done |=> !o_speed_detect_start)
    else $error("trigger restarted while a check is under way");

  a_result_post: assert property (@(posedge i_clk) disable iff (!rst_n)
    spd_evt |=> result_ff == $past(i_speed_detect_result) &&
      u_irq_if.status[ECPS_EVT_SPEED])
    else $error("speed result not posted");

endmodule
`default_nettype wire

/* File: bench/ecps_board.sv */
// Board model: loads on the two soft pins and a speed detection engine
`timescale 1ns/1ps
`default_nettype none
module ecps_board #(
  parameter int ACK_DLY = 3,
  parameter int DONE_DLY = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Soft pins
  input wire ecps_pkg::ecps_pins_t i_pin_out,
  input wire ecps_pkg::ecps_pins_t i_pin_oe,
  input wire ecps_pkg::ecps_pins_t i_ext_level,
  output ecps_pkg::ecps_pins_t o_pin_in,
  // Speed engine
  input wire logic i_start,
  input wire ecps_pkg::ecps_result_t i_result_sel,
  output logic o_ack,
  output logic o_done,
  output ecps_pkg::ecps_result_t o_result
);
  import ecps_pkg::*;
  logic busy_ff;
  int cnt_ff;
  ecps_result_t res_ff;
  // ------------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------------
  // A driven pin reads back the device level, else the board level
  always_comb begin
    for (int i = 0; i < ECPS_NUM_PINS; i++) begin
      o_pin_in[i] = i_pin_oe[i] ? i_pin_out[i] : i_ext_level[i];
    end
  end
  // ------------------------------------------------------------------
  // Engine
  // ------------------------------------------------------------------
  // Result is inverted outside the done pulse, so stale data never matches
  assign o_result = o_done ? res_ff : ~res_ff;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 0;
      o_ack <= 1'b0;
      o_done <= 1'b0;
      res_ff <= 2'h0;
    end else begin
      o_ack <= 1'b0;
      o_done <= 1'b0;
      if (i_start && !o_ack && !busy_ff) begin
        if (cnt_ff == ACK_DLY) begin
          o_ack <= 1'b1;
          busy_ff <= 1'b1;
          cnt_ff <= 0;
        end else begin
          cnt_ff <= cnt_ff + 1;
        end
      end else if (busy_ff) begin
        if (cnt_ff == DONE_DLY) begin
          o_done <= 1'b1;
          res_ff <= i_result_sel;
          busy_ff <= 1'b0;
          cnt_ff <= 0;
        end else begin
          cnt_ff <= cnt_ff + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/test_ecps_top.sv */
// Self-checking bench for the soft pin and speed check block
`timescale 1ns/1ps
`default_nettype none
module test_ecps_top;
  import ecps_pkg::*;
  logic rstn, porn, i_wr, i_rd, i_nvm_load;
  logic i_clk = 1'b0;
  logic rd_q = 1'b0;
  logic start, ack, done, o_irq;
  ecps_addr_t i_addr;
  ecps_data_t i_wdata, o_rdata;
  ecps_pins_t nvm_dir, nvm_val, ext, pin_in, pin_out, pin_oe, v;
  ecps_result_t spd_res, res, r;
  ecps_data_t exp_q[$];
  int err_count, n_checks, cyc;

  ecps_top dut (.i_clk(i_clk), .i_resetn(rstn), .i_por_resetn(porn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_nvm_load(i_nvm_load), .i_nvm_dir(nvm_dir),
    .i_nvm_value(nvm_val), .i_soft_pin_in(pin_in),
    .o_soft_pin_out(pin_out), .o_soft_pin_oe(pin_oe),
    .o_speed_detect_start(start), .i_speed_detect_ack(ack),
    .i_speed_detect_done(done), .i_speed_detect_result(res),
    .o_irq(o_irq));
  ecps_board board (.i_clk(i_clk), .i_resetn(rstn & porn),
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_level(ext),
    .o_pin_in(pin_in), .i_start(start), .i_result_sel(spd_res),
    .o_ack(ack), .o_done(done), .o_result(res));

  always #2.5 i_clk = ~i_clk;
  // ------------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp_read(input ecps_data_t got, input ecps_data_t exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t read got %h exp %h", $time, got, exp);
    end
  endtask
  // Packs irq, output enables and driven levels into one compare
  task automatic cmp_pin(input logic [4:0] exp);
    n_checks++;
    if ({o_irq, pin_oe, pin_out} !== exp) begin
      err_count++;
      $display("ERROR %0t pins got %h exp %h", $time,
        {o_irq, pin_oe, pin_out}, exp);
    end
  endtask
  task automatic cmp_start(input logic exp);
    n_checks++;
    if (start !== exp) begin
      err_count++;
      $display("ERROR %0t start got %h exp %h", $time, start, exp);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        cmp_read(o_rdata, 32'hDEAD_BEEF);
      end else begin
        cmp_read(o_rdata, exp_q.pop_front());
      end
    end
    rd_q <= i_rd;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------------
  task automatic wr(input ecps_addr_t a, input ecps_data_t d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input ecps_addr_t a, input ecps_data_t exp);
    @(posedge i_clk);
    exp_q.push_back(exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic set_ext(input ecps_pins_t l);
    @(posedge i_clk);
    ext <= l;
  endtask
  function automatic ecps_data_t ctrl(input ecps_pins_t en, val, dir,
                                      input logic trig);
    ctrl = ECPS_RST_RDATA;
    ctrl[ECPS_IRQ_EN_LSB +: ECPS_NUM_PINS] = en;
    ctrl[ECPS_VALUE_LSB +: ECPS_NUM_PINS] = val;
    ctrl[ECPS_DIR_LSB +: ECPS_NUM_PINS] = dir;
    ctrl[ECPS_TRIG_BIT] = trig;
  endfunction
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    porn = 1'b0;
    {i_wr, i_rd, i_nvm_load} = 3'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    {nvm_dir, nvm_val, ext, spd_res} = 8'h00;
    void'($urandom(82168));
    repeat (6) @(posedge i_clk);
    rstn <= 1'b1;
    porn <= 1'b1;
    @(posedge i_clk);
    i_nvm_load <= 1'b1;
    nvm_dir <= 2'h3;
    nvm_val <= 2'h2;
    @(posedge i_clk);
    i_nvm_load <= 1'b0;
    idle(1);
    cmp_pin(5'h0E);
    rd(ECPS_OFF_EXT_CTRL, ctrl(2'h0, 2'h2, 2'h3, 1'b0));
    // Software reset must leave pin direction and value alone
    @(posedge i_clk);
    rstn <= 1'b0;
    repeat (6) @(posedge i_clk);
    rstn <= 1'b1;
    idle(1);
    cmp_pin(5'h0E);
    rd(ECPS_OFF_EXT_CTRL, ctrl(2'h0, 2'h2, 2'h3, 1'b0));
    wr(ECPS_OFF_EXT_CTRL, 32'h0000_0CFC);
    idle(1);
    cmp_pin(5'h0F);
    rd(ECPS_OFF_EXT_CTRL, ctrl(2'h3, 2'h3, 2'h3, 1'b0));
    wr(ECPS_OFF_EXT_CTRL, 32'h0000_0000);
    idle(1);
    cmp_pin(5'h00);
    for (int k = 0; k < 4; k++) begin
      v = ecps_pins_t'($urandom);
      set_ext(v);
      idle(3);
      rd(ECPS_OFF_EXT_CTRL, ctrl(2'h0, v, 2'h0, 1'b0));
    end
    // Detection was off, so no rise may have been flagged
    rd(ECPS_OFF_IRQ_STATUS, 32'h0000_0000);
    set_ext(2'h0);
    wr(ECPS_OFF_IRQ_MASK, 32'h0000_0007);
    wr(ECPS_OFF_EXT_CTRL, ctrl(2'h3, 2'h0, 2'h0, 1'b0));
    set_ext(2'h1);
    idle(6);
    cmp_pin(5'h10);
    rd(ECPS_OFF_IRQ_STATUS, 32'h0000_0001);
    idle(2);
    cmp_pin(5'h00);
    wr(ECPS_OFF_IRQ_MASK, 32'h0000_0005);
    rd(ECPS_OFF_IRQ_MASK, 32'h0000_0005);
    set_ext(2'h3);
    idle(6);
    cmp_pin(5'h00);
    rd(ECPS_OFF_IRQ_STATUS, 32'h0000_0002);
    // Speed check with a slow engine; trigger reads back while pending
    r = ecps_result_t'($urandom);
    @(posedge i_clk);
    spd_res <= r;
    wr(ECPS_OFF_EXT_CTRL, 32'h0000_1000);
    rd(ECPS_OFF_EXT_CTRL, ctrl(2'h0, 2'h3, 2'h0, 1'b1));
    #1;
    cmp_start(1'b1);
    for (int i = 0; i < 50 && o_irq !== 1'b1; i++) begin
      idle(1);
    end
    cmp_pin(5'h10);
    cmp_start(1'b0);
    rd(ECPS_OFF_EXT_CTRL, ctrl(2'h0, 2'h3, 2'h0, 1'b0));
    rd(ECPS_OFF_SPEED_RESULT, ecps_data_t'(r));
    rd(ECPS_OFF_IRQ_STATUS, 32'h0000_0004);
    // Unmapped place: write dropped, read gives zero
    wr(8'h20, $urandom);
    rd(8'h20, 32'h0000_0000);
    rd(ECPS_OFF_EXT_CTRL, ctrl(2'h0, 2'h3, 2'h0, 1'b0));
    idle(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
